//--- inc/ampc_pkg.sv
// Constants and types for the amplifier control register target
// Summary of operation
// [RL1] Host writes: start, address, direction zero
// [RL2] Target acknowledges its own address byte
// [RL3] Pointer byte acknowledged, loaded as target
// [RL4] Written data byte stored and acknowledged
// [RL5] Pointer advances after each written byte
// [RL6] Host ends every transfer with stop
// [RL7] Host reads: address write, then pointer
// [RL8] Host turns around: stop-start or repeated start
// [RL9] Address with direction one is acknowledged
// [RL10] Read bytes MSB first, pointer advances
// [RL11] Address is 10110 plus two select pins
// [RL12] Register zero reads fixed identity value
// [RL13] Writing AA to zero restores defaults
// [RL14] Registers above 0A are test only
// [RL15] Run enable low shuts pump and output stage down
// [RL16] Host keeps pump enable while running
// [RL17] Mode bit 3 selects dual use
// [RL18] Mode bit 2 selects linear earpiece
// [RL19] Mode reserved bits hold 1010 and 11
// [RL20] Gain default follows mode: 00 or 10
// [RL21] Nine-bit frames, receiver drives acknowledge low
// [RL22] Foreign address leaves data line released
// [RL23] Writes to read-only registers change nothing
package ampc_pkg;
	localparam int AMPC_NUM_REGS = 11;
	typedef logic [7:0] ampc_byte_t;
	typedef logic [AMPC_NUM_REGS-1:0][7:0] ampc_regs_t;

	// Identity value is arbitrary
	localparam ampc_byte_t AMPC_ID_VALUE = 8'h5C;
	localparam logic [4:0] AMPC_ADDR_FIXED = 5'h16;
	localparam ampc_byte_t AMPC_SOFT_RESET_CMD = 8'hAA;
	localparam logic [3:0] AMPC_BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] AMPC_ONE_BIT = 4'h1;
	localparam ampc_byte_t AMPC_PTR_STEP = 8'h01;

	// --------------------------------------------------------------
	// Register offsets
	// --------------------------------------------------------------
	localparam ampc_byte_t AMPC_REG_ID = 8'h00;
	localparam ampc_byte_t AMPC_REG_SYS = 8'h01;
	localparam ampc_byte_t AMPC_REG_MODE = 8'h02;
	localparam ampc_byte_t AMPC_REG_PUMP_LIMIT = 8'h03;
	localparam ampc_byte_t AMPC_REG_PUMP_PARAM = 8'h04;
	localparam ampc_byte_t AMPC_REG_GAIN = 8'h05;
	localparam ampc_byte_t AMPC_REG_LIM3_POWER = 8'h06;
	localparam ampc_byte_t AMPC_REG_LIM3_TIMING = 8'h07;
	localparam ampc_byte_t AMPC_REG_LIM2_POWER = 8'h08;
	localparam ampc_byte_t AMPC_REG_LIM2_TIMING = 8'h09;
	localparam ampc_byte_t AMPC_REG_LIM1_CTRL = 8'h0A;
	localparam ampc_byte_t AMPC_REG_LAST = AMPC_REG_LIM1_CTRL;

	// --------------------------------------------------------------
	// Field positions and values
	// --------------------------------------------------------------
	localparam int AMPC_BIT_RUN = 3;
	localparam int AMPC_BIT_PUMP = 2;
	localparam int AMPC_BIT_STAGE = 1;
	localparam int AMPC_BIT_DUAL = 3;
	localparam int AMPC_BIT_LINEAR = 2;
	localparam logic [3:0] AMPC_MODE_RSVD_HI = 4'hA;
	localparam logic [1:0] AMPC_MODE_RSVD_LO = 2'h3;
	localparam ampc_byte_t AMPC_GAIN_DUAL = 8'h00;
	localparam ampc_byte_t AMPC_GAIN_SPEAKER = 8'h10;

	// Index 0x0A first, 0x00 last
	localparam ampc_regs_t AMPC_RESET = {8'h96, 8'h08, 8'h06, 8'h52, 8'h07, 8'h10,
		8'h05, 8'h06, 8'hA3, 8'h06, AMPC_ID_VALUE};
	localparam ampc_regs_t AMPC_WMASK = {8'h0D, 8'h1C, 8'h0F, 8'hFC, 8'h0F, 8'h1F,
		8'h00, 8'h0F, 8'h0C, 8'h0E, 8'h00};

	typedef enum logic [8:0] {
		AMPC_ST_IDLE = 9'h001,
		AMPC_ST_ADDR = 9'h002,
		AMPC_ST_ADDR_ACK = 9'h004,
		AMPC_ST_PTR = 9'h008,
		AMPC_ST_PTR_ACK = 9'h010,
		AMPC_ST_WDATA = 9'h020,
		AMPC_ST_WDATA_ACK = 9'h040,
		AMPC_ST_RDATA = 9'h080,
		AMPC_ST_RDATA_ACK = 9'h100
	} ampc_state_t;

	function automatic ampc_byte_t ampc_default_gain(input logic dual);
		return dual ? AMPC_GAIN_DUAL : AMPC_GAIN_SPEAKER;
	endfunction

	function automatic ampc_regs_t ampc_defaults();
		ampc_regs_t r;
		r = AMPC_RESET;
		r[AMPC_REG_GAIN] = ampc_default_gain(r[AMPC_REG_MODE][AMPC_BIT_DUAL]); // RL20
		return r;
	endfunction

	function automatic ampc_byte_t ampc_read(input ampc_regs_t r, input ampc_byte_t ptr);
		return (ptr <= AMPC_REG_LAST) ? r[ptr[3:0]] : 8'h00;
	endfunction
endpackage

//--- inc/ampc_evt_if.sv
// Line events passed from the bus monitor to the target core
`timescale 1ns/1ns
interface ampc_evt_if;
	logic scl_rise;
	logic scl_fall;
	logic start;
	logic stop;
	logic sda_bit;
	modport det (output scl_rise, scl_fall, start, stop, sda_bit);
	modport core (input scl_rise, scl_fall, start, stop, sda_bit);
endinterface // ampc_evt_if

//--- hdl/ampc_line_mon.sv
// Serial bus line monitor: clock edges, start and stop
`timescale 1ns/1ns
module ampc_line_mon
(
	// Clock and reset
	input logic sys_clk,
	input logic resetn,
	// Bus lines
	input logic scl_in,
	input logic sda_in,
	// Events
	ampc_evt_if.det ev
);
	import ampc_pkg::*;

	typedef struct packed {
		logic scl_a;
		logic sda_a;
		logic scl_b;
		logic sda_b;
	} ampc_mon_t;

	ampc_mon_t s;
	ampc_mon_t n;

	always_comb
	begin
		n.scl_a = scl_in;
		n.sda_a = sda_in;
		n.scl_b = s.scl_a;
		n.sda_b = s.sda_a;
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			s <= '1;
		else
			s <= n;
	end

	// Data may only change while the clock is low; a change while high is framing
	assign ev.scl_rise = s.scl_a & ~s.scl_b;
	assign ev.scl_fall = ~s.scl_a & s.scl_b;
	assign ev.start = s.scl_a & s.scl_b & s.sda_b & ~s.sda_a; // RL21
	assign ev.stop = s.scl_a & s.scl_b & ~s.sda_b & s.sda_a;
	assign ev.sda_bit = s.sda_a;

	chk_start_stop_excl: assert property (@(posedge sys_clk) disable iff (!resetn)
		!(ev.start && ev.stop))
		else $error("start and stop flagged together");
endmodule // ampc_line_mon

//--- hdl/ampc_i2c_regs.sv
// Amplifier control register bank behind a serial target port
`timescale 1ns/1ns
module ampc_i2c_regs
(
	// Clock and reset
	input logic sys_clk,
	input logic resetn,
	// Serial bus
	input logic scl_in,
	input logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	// Address select pins
	input logic addr_select_hi_pin,
	input logic addr_select_lo_pin,
	// Control outputs
	output logic chip_run_enable,
	output logic pump_enable,
	output logic output_stage_enable,
	output logic dual_use_select,
	output logic linear_earpiece_select,
	output logic [3:0] pump_limit_voltage,
	output logic [4:0] amp_gain,
	output ampc_pkg::ampc_byte_t limiter_stage3_power,
	output ampc_pkg::ampc_byte_t limiter_stage3_timing,
	output ampc_pkg::ampc_byte_t limiter_stage2_power,
	output ampc_pkg::ampc_byte_t limiter_stage2_timing,
	output ampc_pkg::ampc_byte_t limiter_stage1_control
);
	import ampc_pkg::*;

	typedef struct packed {
		ampc_state_t fsm;
		logic [3:0] bit_cnt;
		ampc_byte_t shift;
		ampc_byte_t ptr;
		logic rd_dir;
		logic host_ack;
		logic sda_o;
		logic oe_n;
		ampc_regs_t regs;
		logic run_en;
		logic pump_en;
		logic stage_en;
		logic dual_sel;
		logic lin_sel;
	} ampc_core_t;

	localparam ampc_core_t AMPC_CORE_RST = '{
		fsm: AMPC_ST_IDLE,
		bit_cnt: '0,
		shift: '0,
		ptr: '0,
		rd_dir: 1'b0,
		host_ack: 1'b0,
		sda_o: 1'b0,
		oe_n: 1'b1,
		regs: ampc_defaults(),
		run_en: 1'b0,
		pump_en: 1'b0,
		stage_en: 1'b0,
		dual_sel: 1'b0,
		lin_sel: 1'b0
	};

	ampc_evt_if ev ();

	ampc_line_mon u_line_mon
	(
		.sys_clk(sys_clk),
		.resetn(resetn),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.ev(ev)
	);

	ampc_core_t s;
	ampc_core_t n;
	logic [6:0] own_addr;
	logic receiving;
	logic byte_done;
	ampc_byte_t rd_next;

	assign own_addr = {AMPC_ADDR_FIXED, addr_select_hi_pin, addr_select_lo_pin}; // RL11
	assign receiving = (s.fsm == AMPC_ST_ADDR) || (s.fsm == AMPC_ST_PTR)
		|| (s.fsm == AMPC_ST_WDATA);
	assign byte_done = receiving && ev.scl_fall && (s.bit_cnt == AMPC_BITS_PER_BYTE);
	assign rd_next = ampc_read(s.regs, s.ptr + AMPC_PTR_STEP);

	// Load a read byte: MSB out now, rest shifted on later falls
	function automatic ampc_core_t start_byte(input ampc_core_t c, input ampc_byte_t d);
		c.sda_o = d[7]; // RL10
		c.shift = {d[6:0], 1'b0};
		c.oe_n = 1'b0;
		c.bit_cnt = AMPC_ONE_BIT;
		c.fsm = AMPC_ST_RDATA;
		return c;
	endfunction

	// Masked store; reserved bits and read-only bytes keep their value
	function automatic ampc_regs_t store_byte(input ampc_regs_t r, input ampc_byte_t p,
		input ampc_byte_t d);
		ampc_regs_t o;
		o = r;
		if ((p == AMPC_REG_ID) && (d == AMPC_SOFT_RESET_CMD))
			o = ampc_defaults(); // RL13
		else if (p <= AMPC_REG_LAST) // RL14
			o[p[3:0]] = (r[p[3:0]] & ~AMPC_WMASK[p[3:0]]) | (d & AMPC_WMASK[p[3:0]]); // RL19 RL23
		return o;
	endfunction

	// ------------------------------------------------------------------
	// Byte sequencer and register file
	// ------------------------------------------------------------------
	always_comb
	begin
		n = s;
		if (ev.stop)
		begin
			n.fsm = AMPC_ST_IDLE;
			n.oe_n = 1'b1;
		end
		else if (ev.start)
		begin
			n.fsm = AMPC_ST_ADDR;
			n.bit_cnt = '0;
			n.oe_n = 1'b1;
		end
		else
		begin
			// Sample on the rising clock, MSB first
			if (receiving && ev.scl_rise && (s.bit_cnt != AMPC_BITS_PER_BYTE))
			begin
				n.shift = {s.shift[6:0], ev.sda_bit}; // RL21
				n.bit_cnt = s.bit_cnt + AMPC_ONE_BIT;
			end
			case (s.fsm)
				AMPC_ST_IDLE:
					n.oe_n = 1'b1;
				AMPC_ST_ADDR:
					if (byte_done)
					begin
						if (s.shift[7:1] == own_addr)
						begin
							n.oe_n = 1'b0; // RL2
							n.sda_o = 1'b0; // RL2
							n.rd_dir = s.shift[0]; // RL9
							n.fsm = AMPC_ST_ADDR_ACK;
						end
						else
							n.fsm = AMPC_ST_IDLE; // RL22
					end
				AMPC_ST_ADDR_ACK:
					if (ev.scl_fall)
					begin
						if (s.rd_dir)
							n = start_byte(n, ampc_read(s.regs, s.ptr)); // RL10 RL12
						else
						begin
							n.oe_n = 1'b1;
							n.bit_cnt = '0;
							n.fsm = AMPC_ST_PTR;
						end
					end
				AMPC_ST_PTR:
					if (byte_done)
					begin
						n.ptr = s.shift; // RL3
						n.oe_n = 1'b0; // RL3
						n.sda_o = 1'b0;
						n.fsm = AMPC_ST_PTR_ACK;
					end
				AMPC_ST_PTR_ACK:
					if (ev.scl_fall)
					begin
						n.oe_n = 1'b1;
						n.bit_cnt = '0;
						n.fsm = AMPC_ST_WDATA;
					end
				AMPC_ST_WDATA:
					if (byte_done)
					begin
						n.regs = store_byte(s.regs, s.ptr, s.shift); // RL4
						n.oe_n = 1'b0; // RL4
						n.sda_o = 1'b0;
						n.fsm = AMPC_ST_WDATA_ACK;
					end
				AMPC_ST_WDATA_ACK:
					if (ev.scl_fall)
					begin
						n.ptr = s.ptr + AMPC_PTR_STEP; // RL5
						n.oe_n = 1'b1;
						n.bit_cnt = '0;
						n.fsm = AMPC_ST_WDATA;
					end
				AMPC_ST_RDATA:
					if (ev.scl_fall)
					begin
						if (s.bit_cnt == AMPC_BITS_PER_BYTE)
						begin
							// Host owns the acknowledge slot
							n.oe_n = 1'b1; // RL21
							n.fsm = AMPC_ST_RDATA_ACK;
						end
						else
						begin
							n.sda_o = s.shift[7]; // RL10
							n.shift = {s.shift[6:0], 1'b0};
							n.bit_cnt = s.bit_cnt + AMPC_ONE_BIT;
						end
					end
				AMPC_ST_RDATA_ACK:
					if (ev.scl_rise)
						n.host_ack = ev.sda_bit; // RL21
					else if (ev.scl_fall)
					begin
						n.ptr = s.ptr + AMPC_PTR_STEP; // RL10
						if (!s.host_ack)
							n = start_byte(n, rd_next); // RL10
						else
							n.fsm = AMPC_ST_IDLE;
					end
				default:
					n.fsm = AMPC_ST_IDLE;
			endcase
		end
		// Run enable gates the pump and the output stage
		n.run_en = n.regs[AMPC_REG_SYS][AMPC_BIT_RUN]; // RL15
		n.pump_en = n.run_en & n.regs[AMPC_REG_SYS][AMPC_BIT_PUMP]; // RL15
		n.stage_en = n.run_en & n.regs[AMPC_REG_SYS][AMPC_BIT_STAGE]; // RL15
		n.dual_sel = n.regs[AMPC_REG_MODE][AMPC_BIT_DUAL]; // RL17
		n.lin_sel = n.regs[AMPC_REG_MODE][AMPC_BIT_LINEAR]; // RL18
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			s <= AMPC_CORE_RST;
		else
			s <= n;
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign sda_out = s.sda_o;
	assign sda_oe_n = s.oe_n;
	assign chip_run_enable = s.run_en;
	assign pump_enable = s.pump_en;
	assign output_stage_enable = s.stage_en;
	assign dual_use_select = s.dual_sel;
	assign linear_earpiece_select = s.lin_sel;
	assign pump_limit_voltage = s.regs[AMPC_REG_PUMP_LIMIT][3:0];
	assign amp_gain = s.regs[AMPC_REG_GAIN][4:0];
	assign limiter_stage3_power = s.regs[AMPC_REG_LIM3_POWER];
	assign limiter_stage3_timing = s.regs[AMPC_REG_LIM3_TIMING];
	assign limiter_stage2_power = s.regs[AMPC_REG_LIM2_POWER];
	assign limiter_stage2_timing = s.regs[AMPC_REG_LIM2_TIMING];
	assign limiter_stage1_control = s.regs[AMPC_REG_LIM1_CTRL];

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	sequence seq_addr_match;
		(s.fsm == AMPC_ST_ADDR) && byte_done && (s.shift[7:1] == own_addr);
	endsequence

	sequence seq_line_low;
		!s.oe_n && !s.sda_o;
	endsequence

	sequence seq_soft_cmd;
		(s.fsm == AMPC_ST_WDATA) && byte_done && (s.ptr == AMPC_REG_ID)
			&& (s.shift == AMPC_SOFT_RESET_CMD);
	endsequence

	chk_addr_ack_low: assert property (@(posedge sys_clk) disable iff (!resetn) // RL2
		seq_addr_match |=> seq_line_low)
		else $error("own address not acknowledged");
	chk_foreign_released: assert property (@(posedge sys_clk) disable iff (!resetn) // RL22
		((s.fsm == AMPC_ST_ADDR) && byte_done && (s.shift[7:1] != own_addr))
			|=> (s.oe_n && (s.fsm == AMPC_ST_IDLE)))
		else $error("foreign address not ignored");
	chk_ptr_step_write: assert property (@(posedge sys_clk) disable iff (!resetn) // RL5
		((s.fsm == AMPC_ST_WDATA_ACK) && ev.scl_fall) |=> (s.ptr == $past(s.ptr) + AMPC_PTR_STEP))
		else $error("pointer did not advance after write");
	chk_soft_reset_all: assert property (@(posedge sys_clk) disable iff (!resetn) // RL13
		seq_soft_cmd |=> (s.regs == ampc_defaults()))
		else $error("soft reset left a register changed");
	chk_run_gates_enables: assert property (@(posedge sys_clk) disable iff (!resetn) // RL15
		!s.run_en |-> (!s.pump_en && !s.stage_en))
		else $error("enable active while run is off");
	chk_id_fixed_value: assert property (@(posedge sys_clk) disable iff (!resetn) // RL12
		s.regs[AMPC_REG_ID] == AMPC_ID_VALUE)
		else $error("identity value changed");
	chk_mode_rsvd_bits: assert property (@(posedge sys_clk) disable iff (!resetn) // RL19
		(s.regs[AMPC_REG_MODE][7:4] == AMPC_MODE_RSVD_HI)
			&& (s.regs[AMPC_REG_MODE][1:0] == AMPC_MODE_RSVD_LO))
		else $error("mode reserved bits changed");
endmodule // ampc_i2c_regs

//--- dv/ampc_host.sv
// Serial bus host model for the register target
`timescale 1ns/1ns
module ampc_host
(
	// Clock
	input logic sys_clk,
	// Bus lines
	input logic sda_line,
	output logic scl,
	output logic sda_low
);
	initial
	begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic wt();
		repeat (6) @(negedge sys_clk);
	endtask
	// Data moves only while the clock is low
	task automatic bit_io(input logic d, output logic q);
		wt();
		scl = 1'b0;
		wt();
		sda_low = ~d;
		wt();
		scl = 1'b1;
		wt();
		q = sda_line;
	endtask
	// Start ends with data low, stop with it released
	task automatic frame(input logic stop);
		wt();
		scl = 1'b0;
		wt();
		sda_low = stop;
		wt();
		scl = 1'b1;
		wt();
		sda_low = ~stop;
	endtask
	task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic k);
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], q[i]);
		bit_io(a, k);
	endtask
endmodule // ampc_host

//--- dv/tb.sv
// Bench for the amplifier control register target
`timescale 1ns/1ns
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
	$display("wrong value %s exp %h got %h", nm, e, g); end end
module tb;
	import ampc_pkg::*;
	localparam logic [6:0] OWN_ADDR = 7'h5A;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic scl, sda_low, sda_out, sda_oe_n, sda_line, ack;
	logic run_en, pump_en, stage_en, dual_sel, lin_sel;
	logic [3:0] plim;
	logic [4:0] gain;
	logic addr_hi = 1'b1;
	logic addr_lo = 1'b0;
	ampc_byte_t lim3p, lim3t, lim2p, lim2t, lim1c, rq;
	int n_mismatch = 0;
	int tests_run = 0;
	always #4 sys_clk = ~sys_clk;
	// Pulled-up line, low when either side pulls it
	assign sda_line = ~sda_low & (sda_oe_n | sda_out);
	ampc_host ampc_host_inst
	(
		.sys_clk(sys_clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low)
	);
	ampc_i2c_regs ampc_i2c_regs_inst
	(
		.sys_clk(sys_clk), .resetn(resetn), .scl_in(scl), .sda_in(sda_line),
		.sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_select_hi_pin(addr_hi),
		.addr_select_lo_pin(addr_lo), .chip_run_enable(run_en), .pump_enable(pump_en),
		.output_stage_enable(stage_en), .dual_use_select(dual_sel),
		.linear_earpiece_select(lin_sel), .pump_limit_voltage(plim), .amp_gain(gain),
		.limiter_stage3_power(lim3p), .limiter_stage3_timing(lim3t),
		.limiter_stage2_power(lim2p), .limiter_stage2_timing(lim2t),
		.limiter_stage1_control(lim1c)
	);
	task automatic send(input ampc_byte_t d, input logic e, input string nm);
		ampc_byte_t q;
		ampc_host_inst.xfer(d, 1'b1, q, ack);
		`CHK(nm, e, ack)
	endtask
	task automatic head(input ampc_byte_t p);
		ampc_host_inst.frame(1'b0);
		send({OWN_ADDR, 1'b0}, 1'b0, "addr ack");
		send(p, 1'b0, "pointer ack");
	endtask
	task automatic wr(input ampc_byte_t p, input ampc_byte_t d[$]);
		head(p);
		foreach (d[i])
			send(d[i], 1'b0, "data ack");
		ampc_host_inst.frame(1'b1);
	endtask
	task automatic rd(input ampc_byte_t p, input ampc_byte_t e[$], input logic rs);
		ampc_byte_t q;
		head(p);
		if (!rs)
			ampc_host_inst.frame(1'b1);
		ampc_host_inst.frame(1'b0);
		send({OWN_ADDR, 1'b1}, 1'b0, "read addr ack");
		foreach (e[i])
		begin
			ampc_host_inst.xfer(8'hFF, i == e.size() - 1, q, ack);
			`CHK("read byte", e[i], q)
		end
		ampc_host_inst.frame(1'b1);
	endtask
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// ----
	// Tests
	// ----
	initial
	begin
		repeat (16) @(negedge sys_clk);
		resetn = 1'b1;
		rd(8'h00, '{AMPC_ID_VALUE, 8'h06, 8'hA3, 8'h06, 8'h05, 8'h10, 8'h07, 8'h52, 8'h06,
			8'h08, 8'h96}, 1'b0);
		`CHK("run enable", 1'b0, run_en)
		`CHK("gain", 5'h10, gain)
		$display("test defaults done");
		wr(8'h01, '{8'h0E, 8'h0C, 8'h08, 8'hFF, 8'h12});
		`CHK("run enable", 1'b1, run_en)
		`CHK("pump enable", 1'b1, pump_en)
		`CHK("stage enable", 1'b1, stage_en)
		`CHK("dual use", 1'b1, dual_sel)
		`CHK("linear", 1'b1, lin_sel)
		`CHK("pump limit", 4'h8, plim)
		`CHK("gain", 5'h12, gain)
		rd(8'h01, '{8'h0E, 8'hAF, 8'h08, 8'h05, 8'h12}, 1'b1);
		$display("test burst done");
		wr(8'h06, '{8'h0C, 8'h24, 8'h09, 8'h14, 8'h0C});
		`CHK("lim3 power", 8'h0C, lim3p)
		`CHK("lim3 timing", 8'h26, lim3t)
		`CHK("lim2 power", 8'h09, lim2p)
		`CHK("lim2 timing", 8'h14, lim2t)
		`CHK("lim1 control", 8'h9E, lim1c)
		wr(8'h00, '{8'h55});
		rd(8'h00, '{AMPC_ID_VALUE}, 1'b1);
		wr(8'h00, '{8'hAA});
		rd(8'h01, '{8'h06, 8'hA3, 8'h06, 8'h05, 8'h10}, 1'b0);
		`CHK("dual use", 1'b0, dual_sel)
		`CHK("lim3 power", 8'h07, lim3p)
		`CHK("lim3 timing", 8'h52, lim3t)
		`CHK("lim2 power", 8'h06, lim2p)
		`CHK("lim2 timing", 8'h08, lim2t)
		`CHK("lim1 control", 8'h96, lim1c)
		$display("test soft reset done");
		ampc_host_inst.frame(1'b0);
		send(8'hB2, 1'b1, "foreign addr");
		send(8'h01, 1'b1, "foreign pointer");
		send(8'h0E, 1'b1, "foreign data");
		ampc_host_inst.frame(1'b1);
		`CHK("run enable", 1'b0, run_en)
		$display("test foreign address done");
		addr_hi = 1'b0;
		addr_lo = 1'b1;
		ampc_host_inst.frame(1'b0);
		send(8'hB2, 1'b0, "moved addr ack");
		send(8'h05, 1'b0, "moved pointer ack");
		ampc_host_inst.frame(1'b0);
		send(8'hB3, 1'b0, "moved read addr ack");
		ampc_host_inst.xfer(8'hFF, 1'b1, rq, ack);
		`CHK("moved read", 8'h10, rq)
		ampc_host_inst.frame(1'b1);
		$display("test address pins done");
		final_report();
	end
	// About four times the expected traffic time
	initial
	begin
		#400000;
		n_mismatch++;
		final_report();
	end
endmodule // tb
